/* File: bench/draf_frame_chk.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// port checker
// ****************************************
module draf_frame_chk
#(
    parameter        AW       = 8,
    parameter [31:0] WAKE_NS  = 200000,
    parameter [31:0] SLOW_CYC = 28000000
)
(
    input wire logic          CLOCK,
    input wire logic          RST,
    input wire logic          SCK,
    input wire logic          CSN,
    input wire logic          MOSI,
    input wire logic          MISO,
    input wire logic          MISO_OE,
    input wire logic [AW-1:0] REG_ADDR,
    input wire logic [7:0]    REG_WDATA,
    input wire logic          REG_WE,
    input wire logic          REG_RE,
    input wire logic [7:0]    REG_RDATA,
    input wire logic          MEASURE_REQ,
    input wire logic          FAST_CTRL_NZ,
    input wire logic          FAST_CONTINUOUS_MEASURE_BIT_ON,
    input wire logic          FIFO_CLEAR,
    input wire logic          CONV_START,
    input wire logic          MEASURE_ACTIVE,
    input wire logic          SLOW_READY,
    input wire logic          EXT_LINK_CRC_ERROR,
    input wire logic          ERROR_CLEAR
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);
    // sync delay of the select line allows a few cycles
    a_oe_idle: assert property (CSN [*6] |-> !MISO_OE)
        else $error("read driver on while deselected");
    a_fifo_cause: assert property (FIFO_CLEAR |->
        MEASURE_REQ && FAST_CTRL_NZ && !FAST_CONTINUOUS_MEASURE_BIT_ON)
        else $error("fifo clear without fast trigger");
    a_fifo_pulse: assert property (FIFO_CLEAR |=> !FIFO_CLEAR)
        else $error("fifo clear longer than a pulse");
    a_no_wr_read: assert property (MISO_OE |-> !REG_WE)
        else $error("register write during read payload");
    a_step_addr: assert property (REG_WE && $past(REG_WE) |->
        REG_ADDR == $past(REG_ADDR) + 1'b1)
        else $error("address did not step by one");
    a_wake_wait: assert property ($rose(MEASURE_REQ) &&
        !MEASURE_ACTIVE |=> !MEASURE_ACTIVE [*8])
        else $error("measure state without wake delay");
    a_err_hold: assert property (EXT_LINK_CRC_ERROR &&
        !ERROR_CLEAR |=> EXT_LINK_CRC_ERROR)
        else $error("crc error flag lost");
    a_err_discard: assert property ($rose(EXT_LINK_CRC_ERROR)
        |-> !REG_WE [*4])
        else $error("write despite crc error");
    c_write: cover property (REG_WE && $past(REG_WE));
    c_read: cover property ($fell(MISO_OE));
    c_fifo: cover property (FIFO_CLEAR);
endmodule // draf_frame_chk

bind draf_frame draf_frame_chk
#(.AW(AW), .WAKE_NS(WAKE_NS), .SLOW_CYC(SLOW_CYC))
draf_frame_chk_inst
(
    .CLOCK(CLOCK), .RST(RST), .SCK(SCK), .CSN(CSN), .MOSI(MOSI),
    .MISO(MISO), .MISO_OE(MISO_OE), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WE(REG_WE), .REG_RE(REG_RE),
    .REG_RDATA(REG_RDATA), .MEASURE_REQ(MEASURE_REQ),
    .FAST_CTRL_NZ(FAST_CTRL_NZ), .FAST_CONTINUOUS_MEASURE_BIT_ON(FAST_CONTINUOUS_MEASURE_BIT_ON),
    .FIFO_CLEAR(FIFO_CLEAR), .CONV_START(CONV_START),
    .MEASURE_ACTIVE(MEASURE_ACTIVE), .SLOW_READY(SLOW_READY),
    .EXT_LINK_CRC_ERROR(EXT_LINK_CRC_ERROR), .ERROR_CLEAR(ERROR_CLEAR)
);
`default_nettype wire

/* File: bench/draf_frame_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "draf_map.vh"
// ****************************************
// frame bench
// ****************************************
module draf_frame_tb;
    localparam int WAKE_CYC = 200;
    logic       CLOCK = 1'b0;
    logic       RST = 1'b1;
    logic       ERROR_CLEAR = 1'b0;
    logic       MEASURE_REQ = 1'b0;
    logic       FAST_CTRL_NZ = 1'b0;
    logic       FAST_CONTINUOUS_MEASURE_BIT_ON = 1'b0;
    wire        SCK, CSN, MOSI, MISO, MISO_OE, REG_WE, REG_RE;
    wire        FIFO_CLEAR, CONV_START, MEASURE_ACTIVE, SLOW_READY;
    wire        EXT_LINK_CRC_ERROR;
    wire  [7:0] REG_ADDR, REG_WDATA;
    wire  [7:0] REG_RDATA = REG_ADDR ^ 8'h5A;
    logic [7:0] wa[$], wd[$], rx[$];
    int         num_errors = 0, n_compared = 0, fifo_cnt = 0, cyc = 0;
    int         conv_cnt = 0, re_cnt = 0;
    draf_frame #(.WAKE_NS(1000), .SLOW_CYC(100)) draf_frame_inst (
        .CLOCK(CLOCK), .RST(RST), .SCK(SCK), .CSN(CSN), .MOSI(MOSI),
        .MISO(MISO), .MISO_OE(MISO_OE), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_WE(REG_WE), .REG_RE(REG_RE),
        .REG_RDATA(REG_RDATA), .MEASURE_REQ(MEASURE_REQ),
        .FAST_CTRL_NZ(FAST_CTRL_NZ), .FAST_CONTINUOUS_MEASURE_BIT_ON(FAST_CONTINUOUS_MEASURE_BIT_ON),
        .FIFO_CLEAR(FIFO_CLEAR), .CONV_START(CONV_START),
        .MEASURE_ACTIVE(MEASURE_ACTIVE), .SLOW_READY(SLOW_READY),
        .EXT_LINK_CRC_ERROR(EXT_LINK_CRC_ERROR), .ERROR_CLEAR(ERROR_CLEAR));
    draf_host draf_host_inst (.CLOCK(CLOCK), .MISO(MISO),
        .MISO_OE(MISO_OE), .SCK(SCK), .CSN(CSN), .MOSI(MOSI));
    always #2.5 CLOCK = ~CLOCK;
    always @(posedge CLOCK)
    begin
        cyc++;
        if (REG_WE === 1'b1)
        begin
            wa.push_back(REG_ADDR);
            wd.push_back(REG_WDATA);
        end
        if (FIFO_CLEAR === 1'b1) fifo_cnt++;
        if (CONV_START === 1'b1) conv_cnt++;
        if (REG_RE === 1'b1) re_cnt++;
        if (cyc == 40000)
        begin
            num_errors++;
            close_out();
        end
    end
    task automatic close_out();
        $display("compared %0d mismatched %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, got);
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [15:0] crc(input logic [7:0] b[$]);
        logic [14:0] c;
        logic        fb;
        c = `DRAF_CRC_SEED;
        foreach (b[k])
            for (int i = 7; i >= 0; i--)
            begin
                fb = b[k][i] ^ c[14];
                c = {c[13:0], 1'b0} ^ (fb ? `DRAF_CRC_POLY : 15'h0000);
            end
        return {c, 1'b0};
    endfunction
    task automatic frame(input logic [7:0] b[$]);
        logic [7:0] r;
        rx = {};
        wa = {};
        wd = {};
        draf_host_inst.start();
        foreach (b[k])
        begin
            draf_host_inst.xfer(b[k], r);
            rx.push_back(r);
        end
        draf_host_inst.stop();
    endtask
    // host-built write frame; flip spoils the crc, cut drops tail bytes
    task automatic wr(input logic [7:0] a, dsc, input logic [7:0] d[$],
                      input logic [15:0] flip, input int cut);
        logic [7:0]  b[$];
        logic [15:0] h, p;
        h = crc({8'hFE, a});
        p = crc(d) ^ flip;
        b = {8'hFE, a, h[15:8], h[7:0], dsc};
        b = {b, d, p[15:8], p[7:0]};
        repeat (cut) void'(b.pop_back());
        frame(b);
    endtask
    task automatic t_write();
        logic [7:0] d[$];
        wr(8'h10, 8'h45, {8'hA1, 8'hB2}, 16'h0000, 0);
        chk("write count", 2, wa.size());
        chk("write addr", 16'h1011, {wa[0], wa[1]});
        chk("write data", 16'hA1B2, {wd[0], wd[1]});
        for (int i = 0; i < 16; i++) d.push_back(8'hC0 + i);
        wr(8'h30, 8'h5B, d, 16'h0000, 0);
        chk("long count", 16, wa.size());
        chk("long last", 16'h3FCF, {wa[15], wd[15]});
        $display("write test done");
    endtask
    task automatic t_faults();
        logic [7:0] bd [4];
        bd = '{8'h05, 8'hC5, 8'h65, 8'h41};
        wr(8'h10, 8'h45, {8'hA1, 8'hB2}, 16'h0002, 0);
        chk("bad crc writes", 0, wa.size());
        chk("crc flag", 1, EXT_LINK_CRC_ERROR);
        @(negedge CLOCK) ERROR_CLEAR = 1'b1;
        @(negedge CLOCK) ERROR_CLEAR = 1'b0;
        chk("flag cleared", 0, EXT_LINK_CRC_ERROR);
        wr(8'h10, 8'h45, {8'hA1, 8'hB2}, 16'h0000, 1);
        chk("cut writes", 0, wa.size());
        foreach (bd[k])
        begin
            wr(8'h10, bd[k], {8'hA1, 8'hB2}, 16'h0000, 0);
            chk("bad desc writes", 0, wa.size());
        end
        $display("fault test done");
    endtask
    task automatic t_read();
        logic [15:0] h, p;
        int          m;
        h = crc({8'hFE, 8'h20});
        p = crc({8'h7A, 8'h7B});
        m = re_cnt;
        frame({8'hFE, 8'h20, h[15:8], h[7:0], 8'h85, 8'hFF, 8'hFF,
               8'hFF, 8'hFF});
        chk("read strobes", 3, re_cnt - m);
        chk("read data", 16'h7A7B, {rx[5], rx[6]});
        chk("read crc", p, {rx[7], rx[8]});
        chk("read writes", 0, wa.size());
        h = crc({8'hFE, 8'h30});
        frame({8'hFE, 8'h30, h[15:8], h[7:0], 8'h80, 8'hFF});
        chk("abort data", 8'h6A, rx[5]);
        chk("abort drive", 0, MISO_OE);
        $display("read test done");
    endtask
    task automatic t_measure();
        int n;
        n = 0;
        @(negedge CLOCK) MEASURE_REQ = 1'b1;
        while (MEASURE_ACTIVE !== 1'b1 && n < 2 * WAKE_CYC) @(negedge CLOCK) n++;
        chk("wake early", 1, n >= WAKE_CYC - 4);
        chk("wake late", 1, n <= WAKE_CYC + 8);
        n = 0;
        while (SLOW_READY !== 1'b1 && n < 200) @(negedge CLOCK) n++;
        chk("slow ready", 1, n <= 110);
        $display("measure test done");
    endtask
    task automatic t_trigger();
        int n, m;
        for (int k = 2; k >= 0; k--)
        begin
            @(negedge CLOCK);
            FAST_CTRL_NZ = (k != 0);
            FAST_CONTINUOUS_MEASURE_BIT_ON = (k == 2);
            n = fifo_cnt;
            m = conv_cnt;
            frame({`DRAF_CONV_TRIGGER});
            chk("fifo clears", n + (k == 1), fifo_cnt);
            chk("conv starts", m + (k == 1), conv_cnt);
        end
        $display("trigger test done");
    endtask
    initial
    begin
        repeat (5) @(negedge CLOCK);
        RST = 1'b0;
        repeat (2) @(negedge CLOCK);
        t_write();
        t_faults();
        t_measure();
        t_trigger();
        t_read();
        close_out();
    end
endmodule // draf_frame_tb
`default_nettype wire

/* File: bench/draf_host.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// host link master, mode 0
// ****************************************
module draf_host
(
    input  wire logic CLOCK,
    input  wire logic MISO,
    input  wire logic MISO_OE,
    output var  logic SCK,
    output var  logic CSN,
    output var  logic MOSI
);
    initial
    begin
        SCK = 1'b0;
        CSN = 1'b1;
        MOSI = 1'b0;
    end
    // odd offset keeps link edges off the core clock edges
    task automatic start();
        @(negedge CLOCK);
        #1.3 CSN = 1'b0;
        #32;
    endtask
    // host shifts header, device answers read payload
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
        begin
            MOSI = tx[i];
            #32 SCK = 1'b1;
            rx[i] = MISO_OE ? MISO : 1'bx;
            #32 SCK = 1'b0;
        end
    endtask
    // released data line shows the inverse, not the last bit
    task automatic stop();
        #64 CSN = 1'b1;
        MOSI = ~MOSI;
        #320;
    endtask
endmodule // draf_host
`default_nettype wire

/* File: core/draf_crc15.v */
`timescale 1ns/1ps
`default_nettype none
`include "draf_map.vh"
// ****************************************
// byte-wide 15-bit crc, msb first
// ****************************************
module draf_crc15
(
    input  wire        CLOCK,
    input  wire        RST,
    input  wire        clear,
    input  wire        load,
    input  wire [7:0]  data,
    output reg  [14:0] crc_r
);
    reg [14:0] crc_nxt;
    integer    i;
    always @*
    begin
        crc_nxt = crc_r;
        for (i = 7; i >= 0; i = i - 1)
        begin
            if (data[i] ^ crc_nxt[14])
                crc_nxt = {crc_nxt[13:0], 1'b0} ^ `DRAF_CRC_POLY;
            else
                crc_nxt = {crc_nxt[13:0], 1'b0};
        end
    end
    always @(posedge CLOCK or posedge RST)
    begin
        if (RST)
            crc_r <= `DRAF_CRC_SEED;
        else if (clear)
            crc_r <= `DRAF_CRC_SEED;
        else if (load)
            crc_r <= crc_nxt;
    end
endmodule // draf_crc15
`default_nettype wire

/* File: core/draf_frame.v */
`timescale 1ns/1ps
`default_nettype none
`include "draf_map.vh"
module draf_frame
#(
    parameter        AW         = 8,
    parameter [31:0] WAKE_NS    = `DRAF_WAKE_NS,
    parameter [31:0] SLOW_CYC   = `DRAF_SLOW_READY_MS * 1000 * `DRAF_CLK_MHZ
)
(
    input  wire          CLOCK,
    input  wire          RST,
    input  wire          SCK,
    input  wire          CSN,
    input  wire          MOSI,
    output wire          MISO,
    output wire          MISO_OE,
    output reg  [AW-1:0] REG_ADDR,
    output reg  [7:0]    REG_WDATA,
    output reg           REG_WE,
    output reg           REG_RE,
    input  wire [7:0]    REG_RDATA,
    input  wire          MEASURE_REQ,
    input  wire          FAST_CTRL_NZ,
    input  wire          FAST_CONTINUOUS_MEASURE_BIT_ON,
    output reg           FIFO_CLEAR,
    output reg           CONV_START,
    output reg           MEASURE_ACTIVE,
    output reg           SLOW_READY,
    output reg           EXT_LINK_CRC_ERROR,
    input  wire          ERROR_CLEAR
);
// ****************************************
// cycle counts
// ****************************************
    localparam [31:0] WAKE_CYC_RAW = (WAKE_NS * `DRAF_CLK_MHZ) / 1000;
    localparam [31:0] WAKE_CYC = (WAKE_CYC_RAW == 0) ? 1 : WAKE_CYC_RAW;
    localparam [3:0] S_CMD = 4'h0, S_ADDR = 4'h1, S_HC0 = 4'h2,
                     S_HC1 = 4'h3, S_DESC = 4'h4, S_DATA = 4'h5,
                     S_DC0 = 4'h6, S_DC1 = 4'h7, S_SKIP = 4'h8,
                     S_TRIG = 4'h9;
    wire       byte_done;
    wire [7:0] rx_byte;
    wire       frame_on;
    wire [14:0] crc;
    reg  [3:0]  st_r;
    reg  [3:0]  st_nxt;
    reg         rd_r;
    reg  [3:0]  ival_r;
    reg  [3:0]  cnt_r;
    reg  [AW-1:0] ptr_r;
    reg  [AW-1:0] pkt_base_r;
    reg  [7:0]  buf_r [0:15];
    reg  [7:0]  tx_byte;
    reg         crc_clr;
    reg         crc_ld;
    reg  [4:0]  wr_idx_r;
    reg  [31:0] wake_cnt_r;
    reg  [31:0] slow_cnt_r;
    reg         err_set;
    wire [7:0] d = rx_byte;
    wire [7:0] tx_byte_or_rx = (rd_r && st_r == S_DATA) ? REG_RDATA : rx_byte;
    wire [AW-1:0] wr_off = {{(AW-5){1'b0}}, wr_idx_r - 5'h01};
    wire desc_ok = (d[`DRAF_DESC_NRW] == ~d[`DRAF_DESC_RW]) &&
                   (d[`DRAF_DESC_CHK_HI] == (d[4] ^ d[3])) &&
                   (d[`DRAF_DESC_CHK_LO] == (d[1] ^ d[0]));
    wire [15:0] crc_pad = {crc, 1'b0};
    draf_spi_shift u_shift
    (
        .CLOCK       (CLOCK),
        .RST         (RST),
        .sck_in      (SCK),
        .csn_in      (CSN),
        .mosi_in     (MOSI),
        .tx_byte     (tx_byte),
        .miso_r      (MISO),
        .frame_on    (frame_on),
        .byte_done_r (byte_done),
        .rx_byte_r   (rx_byte),
        .frame_end   ()
    );
    draf_crc15 u_crc
    (
        .CLOCK (CLOCK),
        .RST   (RST),
        .clear (crc_clr),
        .load  (crc_ld),
        .data  (tx_byte_or_rx),
        .crc_r (crc)
    );
    // drive only during read payload; stops once the synchronised select rises
    assign MISO_OE = frame_on && rd_r &&
                     (st_r == S_DATA || st_r == S_DC0 || st_r == S_DC1);
// ****************************************
// outgoing byte select
// ****************************************
    always @*
    begin
        tx_byte = 8'h00;
        // device drives only read data and its CRCs
        if (rd_r)
        begin
            case (st_r)
                S_DATA:  tx_byte = REG_RDATA;
                S_DC0:   tx_byte = crc_pad[15:8];
                S_DC1:   tx_byte = crc_pad[7:0];
                default: tx_byte = 8'h00;
            endcase
        end
    end
// ****************************************
// frame state machine
// ****************************************
    always @*
    begin
        st_nxt  = st_r;
        crc_clr = 1'b0;
        crc_ld  = 1'b0;
        err_set = 1'b0;
        if (byte_done)
        begin
            case (st_r)
                S_CMD:
                begin
                    if (d == `DRAF_DIRECT_CMD)
                    begin
                        crc_ld  = 1'b1;
                        st_nxt  = S_ADDR;
                    end
                    else if (d == `DRAF_CONV_TRIGGER)
                        st_nxt = S_TRIG;
                    else
                        st_nxt = S_SKIP;
                end
                S_ADDR:
                begin
                    crc_ld = 1'b1;
                    st_nxt = S_HC0;
                end
                S_HC0:
                    st_nxt = (d == crc_pad[15:8]) ? S_HC1 : S_SKIP;
                S_HC1:
                begin
                    // header CRC over command and address
                    crc_clr = 1'b1;
                    st_nxt  = (d == crc_pad[7:0]) ? S_DESC : S_SKIP;
                    err_set = (d != crc_pad[7:0]);
                end
                S_DESC:
                    // no crc load; bad descriptor drops frame
                    st_nxt = desc_ok ? S_DATA : S_SKIP;
                S_DATA:
                begin
                    crc_ld = 1'b1;
                    if (cnt_r == ival_r)
                        st_nxt = S_DC0;
                end
                S_DC0:
                begin
                    st_nxt  = (rd_r || d == crc_pad[15:8]) ? S_DC1 : S_SKIP;
                    err_set = !rd_r && d != crc_pad[15:8];
                end
                S_DC1:
                begin
                    crc_clr = 1'b1;
                    st_nxt  = (rd_r || d == crc_pad[7:0]) ? S_DATA : S_SKIP;
                    err_set = !rd_r && d != crc_pad[7:0];
                end
                default:
                    st_nxt = st_r;
            endcase
        end
        if (!frame_on)
        begin
            st_nxt  = S_CMD;
            crc_clr = 1'b1;
        end
    end
    always @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            st_r       <= S_CMD;
            rd_r       <= 1'b0;
            ival_r     <= 4'h0;
            cnt_r      <= 4'h0;
            ptr_r      <= {AW{1'b0}};
            pkt_base_r <= {AW{1'b0}};
            wr_idx_r   <= 5'h00;
            REG_ADDR   <= {AW{1'b0}};
            REG_WDATA  <= 8'h00;
            REG_WE     <= 1'b0;
            REG_RE     <= 1'b0;
            FIFO_CLEAR <= 1'b0;
            CONV_START <= 1'b0;
            EXT_LINK_CRC_ERROR <= 1'b0;
        end
        else
        begin
            st_r       <= st_nxt;
            REG_WE     <= 1'b0;
            REG_RE     <= 1'b0;
            FIFO_CLEAR <= 1'b0;
            CONV_START <= 1'b0;
            // set wins over clear
            if (err_set)
                EXT_LINK_CRC_ERROR <= 1'b1;
            else if (ERROR_CLEAR)
                EXT_LINK_CRC_ERROR <= 1'b0;
            if (!frame_on)
                rd_r <= 1'b0;
            if (byte_done)
            begin
                case (st_r)
                    S_CMD:
                        if (d == `DRAF_CONV_TRIGGER && MEASURE_ACTIVE &&
                            FAST_CTRL_NZ && !FAST_CONTINUOUS_MEASURE_BIT_ON)
                        begin
                            FIFO_CLEAR <= 1'b1;
                            CONV_START <= 1'b1;
                        end
                    S_ADDR:
                    begin
                        ptr_r      <= d[AW-1:0];
                        pkt_base_r <= d[AW-1:0];
                        REG_ADDR   <= d[AW-1:0];
                    end
                    S_DESC:
                    begin
                        rd_r   <= d[`DRAF_DESC_RW] & desc_ok;
                        // interval field split in two pairs
                        ival_r <= {d[4], d[3], d[1], d[0]};
                        cnt_r  <= 4'h0;
                        // reads of any register, incl. FIFOs
                        REG_RE <= d[`DRAF_DESC_RW] & desc_ok;
                    end
                    S_DATA:
                    begin
                        cnt_r <= (cnt_r == ival_r) ? 4'h0 : cnt_r + 4'h1;
                        buf_r[cnt_r] <= d;
                        ptr_r    <= ptr_r + {{(AW-1){1'b0}}, 1'b1};
                        REG_ADDR <= ptr_r + {{(AW-1){1'b0}}, 1'b1};
                        REG_RE   <= rd_r;
                    end
                    S_DC1:
                    begin
                        // commit only after complete good CRC
                        if (!rd_r && d == crc_pad[7:0])
                            wr_idx_r <= 5'h01;
                        else
                            pkt_base_r <= ptr_r;
                    end
                    default: ;
                endcase
            end
            // drain verified packet one byte per clock
            if (wr_idx_r != 5'h00)
            begin
                REG_WE    <= 1'b1;
                REG_ADDR  <= pkt_base_r + wr_off;
                REG_WDATA <= buf_r[wr_idx_r[3:0] - 4'h1];
                if (wr_idx_r == {1'b0, ival_r} + 5'h01)
                begin
                    wr_idx_r   <= 5'h00;
                    pkt_base_r <= ptr_r;
                end
                else
                    wr_idx_r <= wr_idx_r + 5'h01;
            end
        end
    end
// ****************************************
// standby to measure
// ****************************************
    always @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            wake_cnt_r     <= 32'h0;
            slow_cnt_r     <= 32'h0;
            MEASURE_ACTIVE <= 1'b0;
            SLOW_READY     <= 1'b0;
        end
        else if (!MEASURE_REQ)
        begin
            MEASURE_ACTIVE <= 1'b0;
            SLOW_READY     <= 1'b0;
            wake_cnt_r     <= 32'h0;
            slow_cnt_r     <= 32'h0;
        end
        // wake delay, then slow results in time
        else if (!MEASURE_ACTIVE)
        begin
            wake_cnt_r <= wake_cnt_r + 32'h1;
            if (wake_cnt_r + 32'h1 >= WAKE_CYC)
                MEASURE_ACTIVE <= 1'b1;
        end
        else if (!SLOW_READY)
        begin
            slow_cnt_r <= slow_cnt_r + 32'h1;
            if (slow_cnt_r + 32'h1 >= SLOW_CYC)
                SLOW_READY <= 1'b1;
        end
    end
endmodule // draf_frame
`default_nettype wire

/* File: core/draf_map.vh */
`ifndef DRAF_MAP_VH
`define DRAF_MAP_VH
// ****************************************
// frame constants
// ****************************************
`define DRAF_DIRECT_CMD      8'hFE
`define DRAF_CONV_TRIGGER    8'hFB
`define DRAF_RESULT_READ     8'hF8
`define DRAF_DESC_RW         7
`define DRAF_DESC_NRW        6
`define DRAF_DESC_CHK_HI     5
`define DRAF_DESC_CHK_LO     2
`define DRAF_CRC_SEED        15'h0010
`define DRAF_CRC_POLY        15'h4599
`define DRAF_MEASURE_BIT     3
`define DRAF_WAKE_NS         200000
`define DRAF_CLK_MHZ         200
`define DRAF_SLOW_READY_MS   140
`endif

/* File: core/draf_spi_shift.v */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// spi slave byte shifter, mode 0
// ****************************************
module draf_spi_shift
(
    input  wire       CLOCK,
    input  wire       RST,
    input  wire       sck_in,
    input  wire       csn_in,
    input  wire       mosi_in,
    input  wire [7:0] tx_byte,
    output reg        miso_r,
    output wire       frame_on,
    output reg        byte_done_r,
    output reg  [7:0] rx_byte_r,
    output wire       frame_end
);
    // two-flop synchronisers; first stage read by second only
    reg [1:0] sck_s_r;
    reg [1:0] csn_s_r;
    reg [1:0] mosi_s_r;
    reg       sck_d_r;
    reg       csn_d_r;
    reg [2:0] bit_r;
    reg [6:0] sh_r;
    reg [7:0] tx_r;
    wire rise = sck_s_r[1] & ~sck_d_r;
    wire fall = ~sck_s_r[1] & sck_d_r;
    assign frame_on  = ~csn_s_r[1];
    assign frame_end = csn_s_r[1] & ~csn_d_r;
    always @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            sck_s_r     <= 2'h0;
            csn_s_r     <= 2'h3;
            mosi_s_r    <= 2'h0;
            sck_d_r     <= 1'b0;
            csn_d_r     <= 1'b1;
            bit_r       <= 3'h0;
            sh_r        <= 7'h00;
            tx_r        <= 8'h00;
            rx_byte_r   <= 8'h00;
            byte_done_r <= 1'b0;
            miso_r      <= 1'b0;
        end
        else
        begin
            sck_s_r     <= {sck_s_r[0], sck_in};
            csn_s_r     <= {csn_s_r[0], csn_in};
            mosi_s_r    <= {mosi_s_r[0], mosi_in};
            sck_d_r     <= sck_s_r[1];
            csn_d_r     <= csn_s_r[1];
            byte_done_r <= 1'b0;
            if (!frame_on)
            begin
                bit_r  <= 3'h0;
                tx_r   <= tx_byte;
                miso_r <= tx_byte[7];
            end
            else if (rise)
            begin
                sh_r  <= {sh_r[5:0], mosi_s_r[1]};
                bit_r <= bit_r + 3'h1;
                if (bit_r == 3'h7)
                begin
                    rx_byte_r   <= {sh_r, mosi_s_r[1]};
                    byte_done_r <= 1'b1;
                end
            end
            else if (fall)
            begin
                if (bit_r == 3'h0)
                begin
                    tx_r   <= tx_byte;
                    miso_r <= tx_byte[7];
                end
                else
                    miso_r <= tx_r[3'h7 - bit_r];
            end
        end
    end
endmodule // draf_spi_shift
`default_nettype wire
